// >>> inc/spics_map.vh
`ifndef SPICS_MAP_VH
`define SPICS_MAP_VH

// Chip select code driven while no transfer runs (all lines high)
`define SPICS_CS_IDLE 4'hf
// Smallest gap between chip selects, in gap periods
`define SPICS_CSGAP_MIN 8'h06
// Default divisor of the slow clock select path
`define SPICS_SLOW_DIV 32
// Shift giving 32 master clocks per unit of the transfer gap field
`define SPICS_XGAP_SHIFT 5
// Transmit word field positions
`define SPICS_TDR_PCS_LO 16
`define SPICS_TDR_LAST_BIT 24
// Serial word length limits in bits
`define SPICS_NBITS_MIN 5'h08
`define SPICS_NBITS_MAX 5'h10
// Width of the wait and baud counters
`define SPICS_CNT_W 14

`endif

// >>> rtl/spics_delay.v
`timescale 1ns/1ps
// Loadable down counter used for every programmable wait and for the baud
// half period; o_zero flags an expired count
module spics_delay #(
  parameter W = 14
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_load,
  input wire [W-1:0] i_value,
  input wire i_tick,
  output wire o_zero
);
  reg [W-1:0] cnt_reg; // Remaining ticks

  // Load wins over counting so a restart is never lost
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_reg <= {W{1'b0}};
    end else if (i_load) begin
      cnt_reg <= i_value;
    end else if (i_tick && (cnt_reg != {W{1'b0}})) begin
      cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign o_zero = (cnt_reg == {W{1'b0}});
endmodule // spics_delay

// >>> rtl/spics_top.v
// What this block does
// - One shared gap between different chip selects
// - Per-select lead delay before first clock edge
// - Per-select gap between same-select transfers
// - Chip selects high outside transfers unless hold or a queued word keeps one low
// - Fixed mode takes select from mode field
// - Variable mode takes select from each word
// - Word carries data, select, final flag
// - Decode mode drives encoded select number
// - Without decode only lowest line goes low
// - Decode mode outputs select field directly
// - Idle code all ones on select lines
// - Config n serves decoded codes 4n..4n+3
// - Release selects after last written word
// - Hold keeps select until peripheral changes
// - Master flags external low on slave select
// - Conflict flag set, unit disabled until enable
// - Conflict detection on unless turned off
// - Slave shifts after select falls, config zero
// - Slave drives MISO, samples MOSI
// - Slave word to holding, overrun drops word
// - Slave resends shift register, resets zero
// - First slave write direct, later at start
// - Chip select gap at least six periods
// - Select map xxx0/xx01/x011, all ones none
// - Final flag releases select despite hold
`timescale 1ns/1ps
`include "spics_map.vh"
module spics_top #(
  parameter SLOW_DIV = `SPICS_SLOW_DIV
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_master,
  input wire i_select_mode_bit,
  input wire i_select_decode_bit,
  input wire i_slow_clock_select,
  input wire i_conflict_detect_off,
  input wire [3:0] i_peripheral_select_field,
  input wire [7:0] i_cs_gap_delay,
  input wire [31:0] i_clock_lead_delay,
  input wire [31:0] i_transfer_gap_delay,
  input wire [31:0] i_baud_div,
  input wire [15:0] i_bits_len,
  input wire [3:0] i_clock_polarity_bit,
  input wire [3:0] i_clock_phase_bit,
  input wire [3:0] i_hold_select_after_transfer,
  input wire i_unit_enable_cmd,
  input wire i_unit_disable_cmd,
  input wire i_tx_write,
  input wire [31:0] i_tx_word,
  input wire i_status_read,
  input wire i_rx_read,
  input wire i_slave_select_in,
  input wire i_serial_clock_pin,
  input wire i_mosi,
  input wire i_miso,
  output wire [3:0] o_chip_select_lines,
  output wire [3:0] o_chip_select_oe,
  output wire o_serial_clock_out,
  output wire o_serial_clock_oe,
  output wire o_mosi,
  output wire o_mosi_oe,
  output wire o_miso,
  output wire o_miso_oe,
  output wire [15:0] o_rx_data,
  output wire [3:0] o_rx_pcs,
  output wire o_rx_full_flag,
  output wire o_rx_overrun_flag,
  output wire o_tx_empty_flag,
  output wire o_master_conflict_flag,
  output wire o_unit_enabled
);
  localparam CW = `SPICS_CNT_W;
  localparam [2:0] ST_IDLE = 3'd0; // Waiting for a word
  localparam [2:0] ST_CSGAP = 3'd1; // Select released, gap running
  localparam [2:0] ST_LEAD = 3'd2; // Select asserted, lead delay running
  localparam [2:0] ST_SHIFT = 3'd3; // Clocking bits
  localparam [2:0] ST_TGAP = 3'd4; // Gap after a word on the same select

  // Pin synchronisers, stage 1 read only by stage 2
  reg [1:0] ss_sync_reg;
  reg [1:0] sck_sync_reg;
  reg [1:0] mosi_sync_reg;
  reg [1:0] miso_sync_reg;
  reg ss_prev_reg; // Last synced select level
  reg sck_prev_reg; // Last synced clock level
  // Control and status state
  reg enabled_reg;
  reg conflict_reg;
  reg ovr_reg;
  reg rxf_reg;
  reg [15:0] rxd_reg;
  reg [3:0] rxpcs_reg;
  reg [15:0] tdr_reg; // Transmit holding data
  reg [3:0] tdr_pcs_reg; // Select carried by the word
  reg tdr_last_reg; // Final flag carried by the word
  reg tdr_full_reg;
  reg txe_reg; // Flopped empty flag, one cycle behind the holding state
  reg sl_pre_reg; // Slave took its first write directly
  reg [2:0] st_reg;
  reg [3:0] cs_reg;
  reg [3:0] cs_oe_reg;
  reg [1:0] idx_reg; // Config slot of the current select
  reg last_reg; // Final flag of the word in flight
  reg [15:0] sh_reg; // Shared shift register
  reg lat_reg; // Bit sampled on a leading edge
  reg dout_reg;
  reg [4:0] ecnt_reg; // Serial clock edges in this word
  reg sck_reg;
  reg sck_oe_reg;
  reg miso_oe_reg;
  reg w_load_reg;
  reg [CW-1:0] w_val_reg;
  reg w_slow_reg; // Wait counts slow ticks
  reg b_load_reg;
  reg [7:0] slow_cnt_reg;
  reg [2:0] own_hist_reg; // Our own recent drive of line 0

  // Config slot in use: slave mode always uses slot zero
  wire [1:0] idx = i_master ? idx_reg : 2'd0;
  wire [3:0] bits_f = i_bits_len[{idx, 2'b00} +: 4];
  wire [4:0] nbits = (bits_f > 4'd8) ? `SPICS_NBITS_MAX : (`SPICS_NBITS_MIN + {1'b0, bits_f});
  wire [4:0] nsh = `SPICS_NBITS_MAX - nbits; // Left alignment shift
  wire clock_polarity_bit = i_clock_polarity_bit[idx];
  wire clock_phase_bit = i_clock_phase_bit[idx];
  wire hold = i_hold_select_after_transfer[idx];
  wire [7:0] lead_f = i_clock_lead_delay[{idx, 3'b000} +: 8];
  wire [7:0] xgap_f = i_transfer_gap_delay[{idx, 3'b000} +: 8];
  wire [7:0] baud_f = i_baud_div[{idx, 3'b000} +: 8];
  wire [15:0] mask = 16'hffff >> nsh;
  wire [15:0] tdr_align = tdr_reg << nsh;

  // Target select of the pending word
  wire [3:0] tgt_pcs = i_select_mode_bit ? tdr_pcs_reg : i_peripheral_select_field;
  reg [3:0] tgt_cs;
  reg [1:0] tgt_idx;

  // Without decoding the lowest-numbered low bit wins so at most one line falls
  always @* begin
    tgt_cs = `SPICS_CS_IDLE;
    tgt_idx = 2'd0;
    if (i_select_decode_bit) begin
      tgt_cs = tgt_pcs;
      tgt_idx = tgt_pcs[3:2];
    end else if (!tgt_pcs[0]) begin
      tgt_cs = 4'he;
    end else if (!tgt_pcs[1]) begin
      tgt_cs = 4'hd;
      tgt_idx = 2'd1;
    end else if (!tgt_pcs[2]) begin
      tgt_cs = 4'hb;
      tgt_idx = 2'd2;
    end else if (!tgt_pcs[3]) begin
      tgt_cs = 4'h7;
      tgt_idx = 2'd3;
    end
  end
  wire tgt_none = (tgt_cs == `SPICS_CS_IDLE);

  // Ticks of the slow clock select path
  wire slow_tick = (slow_cnt_reg == SLOW_DIV[7:0] - 8'd1);
  wire b_tick = i_slow_clock_select ? slow_tick : 1'b1;
  wire w_tick = w_slow_reg ? slow_tick : 1'b1;
  wire w_zero;
  wire b_zero;
  wire w_done = w_zero && !w_load_reg;
  wire [7:0] half_div = (baud_f[7:1] == 7'd0) ? 8'd1 : {1'b0, baud_f[7:1]};
  // Gap field of six or less falls back to six periods
  wire [7:0] gap_per = (i_cs_gap_delay <= `SPICS_CSGAP_MIN) ? `SPICS_CSGAP_MIN
                       : i_cs_gap_delay;

  spics_delay #(.W(CW)) u_wait (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_load(w_load_reg),
    .i_value(w_val_reg),
    .i_tick(w_tick),
    .o_zero(w_zero)
  );

  spics_delay #(.W(CW)) u_baud (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_load(b_load_reg),
    .i_value({{(CW-8){1'b0}}, half_div - 8'd1}),
    .i_tick(b_tick),
    .o_zero(b_zero)
  );

  // Serial edge events, master from the baud counter, slave from the pin
  wire ss_low = !ss_sync_reg[1];
  wire slv_act = enabled_reg && !i_master && ss_low;
  wire m_evt = enabled_reg && i_master && (st_reg == ST_SHIFT) && !b_load_reg
               && b_zero && b_tick;
  wire s_edge = slv_act && (sck_sync_reg[1] != sck_prev_reg);
  wire edge_evt = m_evt || s_edge;
  wire leading = !ecnt_reg[0];
  wire in_bit = i_master ? miso_sync_reg[1] : mosi_sync_reg[1];
  wire [15:0] sh_shift = {sh_reg[14:0], clock_phase_bit ? lat_reg : in_bit};
  wire word_end = edge_evt && !leading && (ecnt_reg == {nbits[3:0], 1'b1} - 5'd2);
  wire ss_fall = ss_prev_reg && ss_low;
  // Outside low on line 0 while we have kept it high for three cycles
  wire fault = enabled_reg && i_master && !i_conflict_detect_off && ss_low
               && (&own_hist_reg);

  // Synchronisers and edge history
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ss_sync_reg <= 2'b11;
      sck_sync_reg <= 2'b00;
      mosi_sync_reg <= 2'b00;
      miso_sync_reg <= 2'b00;
      ss_prev_reg <= 1'b1;
      sck_prev_reg <= 1'b0;
      slow_cnt_reg <= 8'd0;
      own_hist_reg <= 3'b111;
      txe_reg <= 1'b1;
    end else begin
      txe_reg <= !tdr_full_reg;
      ss_sync_reg <= {ss_sync_reg[0], i_slave_select_in};
      sck_sync_reg <= {sck_sync_reg[0], i_serial_clock_pin};
      mosi_sync_reg <= {mosi_sync_reg[0], i_mosi};
      miso_sync_reg <= {miso_sync_reg[0], i_miso};
      ss_prev_reg <= ss_sync_reg[1];
      sck_prev_reg <= sck_sync_reg[1];
      slow_cnt_reg <= slow_tick ? 8'd0 : slow_cnt_reg + 8'd1;
      own_hist_reg <= {own_hist_reg[1:0], cs_reg[0] || !cs_oe_reg[0]};
    end
  end

  // Receive holding register and sticky flags; a set beats a clear
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rxd_reg <= 16'h0000;
      rxpcs_reg <= 4'h0;
      rxf_reg <= 1'b0;
      ovr_reg <= 1'b0;
      conflict_reg <= 1'b0;
    end else begin
      if (word_end && rxf_reg) begin
        ovr_reg <= 1'b1;
      end else if (i_status_read) begin
        ovr_reg <= 1'b0;
      end
      if (word_end && !rxf_reg) begin
        rxd_reg <= sh_shift & mask;
        rxpcs_reg <= i_master ? cs_reg : 4'h0;
        rxf_reg <= 1'b1;
      end else if (i_rx_read) begin
        rxf_reg <= 1'b0;
      end
      if (fault) begin
        conflict_reg <= 1'b1;
      end else if (i_status_read) begin
        conflict_reg <= 1'b0;
      end
    end
  end

  // Transfer engine for both modes
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      enabled_reg <= 1'b0;
      tdr_reg <= 16'h0000;
      tdr_pcs_reg <= 4'h0;
      tdr_last_reg <= 1'b0;
      tdr_full_reg <= 1'b0;
      sl_pre_reg <= 1'b0;
      st_reg <= ST_IDLE;
      cs_reg <= `SPICS_CS_IDLE;
      cs_oe_reg <= 4'h0;
      idx_reg <= 2'd0;
      last_reg <= 1'b0;
      sh_reg <= 16'h0000;
      lat_reg <= 1'b0;
      dout_reg <= 1'b0;
      ecnt_reg <= 5'd0;
      sck_reg <= 1'b0;
      sck_oe_reg <= 1'b0;
      miso_oe_reg <= 1'b0;
      w_load_reg <= 1'b0;
      w_val_reg <= {CW{1'b0}};
      w_slow_reg <= 1'b0;
      b_load_reg <= 1'b0;
    end else begin
      w_load_reg <= 1'b0;
      b_load_reg <= 1'b0;
      // Disable wins over enable; a fault disables at once
      if (i_unit_disable_cmd || fault) begin
        enabled_reg <= 1'b0;
      end else if (i_unit_enable_cmd) begin
        enabled_reg <= 1'b1;
      end
      cs_oe_reg <= {4{enabled_reg && i_master}};
      sck_oe_reg <= enabled_reg && i_master;
      miso_oe_reg <= slv_act;
      // Transmit write: data low, select and final flag high
      if (i_tx_write) begin
        if (!i_master && !sl_pre_reg && !ss_low) begin
          sh_reg <= i_tx_word[15:0] << nsh;
          dout_reg <= i_tx_word[15 - nsh];
          sl_pre_reg <= 1'b1;
        end else begin
          tdr_reg <= i_tx_word[15:0];
          tdr_pcs_reg <= i_tx_word[`SPICS_TDR_PCS_LO +: 4];
          tdr_last_reg <= i_tx_word[`SPICS_TDR_LAST_BIT];
          tdr_full_reg <= 1'b1;
        end
      end
      // Shared bit engine: shift on the trailing edge, sample on the leading one only with clock_phase_bit set
      if (edge_evt) begin
        if (leading) begin
          if (clock_phase_bit) begin
            lat_reg <= in_bit;
          end else begin
            dout_reg <= sh_reg[15];
          end
        end else begin
          sh_reg <= sh_shift;
          if (clock_phase_bit) begin
            dout_reg <= sh_reg[14];
          end
        end
        ecnt_reg <= word_end ? 5'd0 : ecnt_reg + 5'd1;
      end
      if (!enabled_reg) begin
        // Disabled: selects idle and no word in flight
        st_reg <= ST_IDLE;
        cs_reg <= `SPICS_CS_IDLE;
        ecnt_reg <= 5'd0;
        sl_pre_reg <= 1'b0;
      end else if (!i_master) begin
        cs_reg <= `SPICS_CS_IDLE;
        st_reg <= ST_IDLE;
        if (!ss_low) begin
          ecnt_reg <= 5'd0;
        end
        // Newest write loads at select fall or after a word
        if ((ss_fall || word_end) && tdr_full_reg && !i_tx_write) begin
          sh_reg <= tdr_align;
          dout_reg <= tdr_align[15];
          tdr_full_reg <= 1'b0;
        end else if (word_end) begin
          sh_reg <= sh_shift << nsh;
          dout_reg <= sh_shift[15 - nsh];
        end
      end else begin
        if (m_evt) begin
          sck_reg <= !sck_reg;
          b_load_reg <= 1'b1;
        end
        case (st_reg)
          ST_IDLE: begin
            if (tdr_full_reg && !i_tx_write) begin
              if (tgt_none) begin
                tdr_full_reg <= 1'b0;
              end else if ((cs_reg != `SPICS_CS_IDLE)
                           && ((cs_reg != tgt_cs) || last_reg)) begin
                cs_reg <= `SPICS_CS_IDLE;
                st_reg <= ST_CSGAP;
                w_load_reg <= 1'b1;
                w_val_reg <= {{(CW-8){1'b0}}, gap_per - 8'd1};
                w_slow_reg <= i_slow_clock_select;
              end else if (cs_reg == tgt_cs) begin
                st_reg <= ST_SHIFT;
                sh_reg <= tdr_align;
                dout_reg <= tdr_align[15];
                tdr_full_reg <= 1'b0;
                last_reg <= tdr_last_reg;
                ecnt_reg <= 5'd0;
                b_load_reg <= 1'b1;
                sck_reg <= clock_polarity_bit;
              end else begin
                cs_reg <= tgt_cs;
                idx_reg <= tgt_idx;
                sck_reg <= i_clock_polarity_bit[tgt_idx];
                st_reg <= ST_LEAD;
                w_load_reg <= 1'b1;
                w_val_reg <= {{(CW-8){1'b0}}, i_clock_lead_delay[{tgt_idx, 3'b000} +: 8]};
                w_slow_reg <= 1'b0;
              end
            end
          end
          ST_CSGAP: begin
            if (w_done) begin
              st_reg <= ST_IDLE;
            end
          end
          ST_LEAD: begin
            // First clock edge only after the lead delay
            if (w_done) begin
              st_reg <= ST_SHIFT;
              sh_reg <= tdr_align;
              dout_reg <= tdr_align[15];
              tdr_full_reg <= i_tx_write;
              last_reg <= tdr_last_reg;
              ecnt_reg <= 5'd0;
              b_load_reg <= 1'b1;
              sck_reg <= clock_polarity_bit;
            end
          end
          ST_SHIFT: begin
            if (word_end) begin
              if (tdr_full_reg || (hold && !tdr_last_reg && !last_reg)) begin
                st_reg <= ST_TGAP;
                w_load_reg <= 1'b1;
                w_val_reg <= {{(CW-8-`SPICS_XGAP_SHIFT){1'b0}}, xgap_f,
                              {`SPICS_XGAP_SHIFT{1'b0}}};
                w_slow_reg <= 1'b0;
              end else begin
                cs_reg <= `SPICS_CS_IDLE;
                st_reg <= ST_CSGAP;
                w_load_reg <= 1'b1;
                w_val_reg <= {{(CW-8){1'b0}}, gap_per - 8'd1};
                w_slow_reg <= i_slow_clock_select;
              end
            end
          end
          ST_TGAP: begin
            if (w_done) begin
              st_reg <= ST_IDLE;
            end
          end
          default: begin
            st_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  assign o_chip_select_lines = cs_reg;
  assign o_chip_select_oe = cs_oe_reg;
  assign o_serial_clock_out = sck_reg;
  assign o_serial_clock_oe = sck_oe_reg;
  assign o_mosi = dout_reg;
  assign o_mosi_oe = sck_oe_reg;
  assign o_miso = dout_reg;
  assign o_miso_oe = miso_oe_reg;
  assign o_rx_data = rxd_reg;
  assign o_rx_pcs = rxpcs_reg;
  assign o_rx_full_flag = rxf_reg;
  assign o_rx_overrun_flag = ovr_reg;
  assign o_tx_empty_flag = txe_reg;
  assign o_master_conflict_flag = conflict_reg;
  assign o_unit_enabled = enabled_reg;
endmodule // spics_top

// >>> testbench/spics_checker.sv
`timescale 1ns/1ps
// Watches the select, clock and flag outputs of the chip select block
module spics_checker #(
  parameter SLOW_DIV = 32
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_select_mode_bit,
  input wire i_select_decode_bit,
  input wire i_conflict_detect_off,
  input wire [3:0] i_peripheral_select_field,
  input wire [31:0] i_clock_lead_delay,
  input wire i_status_read,
  input wire [3:0] o_chip_select_lines,
  input wire o_serial_clock_out,
  input wire [15:0] o_rx_data,
  input wire o_rx_full_flag,
  input wire o_rx_overrun_flag,
  input wire o_master_conflict_flag,
  input wire o_unit_enabled
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  reg [15:0] lead_cnt_reg; // Cycles since a select went low
  // Count select time; saturates so long holds never wrap back to a small value
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      lead_cnt_reg <= 16'h0000;
    end else if (o_chip_select_lines == 4'hf) begin
      lead_cnt_reg <= 16'h0000;
    end else if (lead_cnt_reg != 16'hffff) begin
      lead_cnt_reg <= lead_cnt_reg + 16'h0001;
    end
  end
  // Lines expected for a select field without decoding
  function automatic [3:0] sel_map(input [3:0] f);
    casez (f)
      4'b???0: sel_map = 4'b1110;
      4'b??01: sel_map = 4'b1101;
      4'b?011: sel_map = 4'b1011;
      4'b0111: sel_map = 4'b0111;
      default: sel_map = 4'b1111;
    endcase
  endfunction
  sequence s_select;
    $fell(o_chip_select_lines == 4'hf);
  endsequence
  sequence s_release;
    $rose(o_chip_select_lines == 4'hf);
  endsequence
  AST_ONE_LINE: assert property (!i_select_decode_bit |-> $onehot0(~o_chip_select_lines))
    else $error("more than one select line low");
  AST_GAP: assert property (s_release |-> (o_chip_select_lines == 4'hf) [*6])
    else $error("select gap too short");
  AST_FIXED_MAP: assert property (s_select ##0 (!i_select_mode_bit && !i_select_decode_bit)
    |-> o_chip_select_lines == sel_map(i_peripheral_select_field))
    else $error("fixed select lines wrong");
  AST_DECODE: assert property (s_select ##0 (!i_select_mode_bit && i_select_decode_bit)
    |-> o_chip_select_lines == i_peripheral_select_field)
    else $error("decoded select code wrong");
  AST_LEAD: assert property ($changed(o_serial_clock_out) && o_chip_select_lines == 4'he
    |-> lead_cnt_reg >= {8'h00, i_clock_lead_delay[7:0]})
    else $error("serial clock before lead delay");
  AST_IDLE: assert property (!o_unit_enabled && !$past(o_unit_enabled)
    |-> o_chip_select_lines == 4'hf)
    else $error("select low while disabled");
  AST_FAULT_OFF: assert property ($rose(o_master_conflict_flag) |-> !i_conflict_detect_off)
    else $error("conflict flagged while detection off");
  AST_FAULT_STOP: assert property ($rose(o_master_conflict_flag) |-> ##[0:1] !o_unit_enabled)
    else $error("unit still enabled after conflict");
  AST_FAULT_CLEAR: assert property ($fell(o_master_conflict_flag) |-> $past(i_status_read))
    else $error("conflict flag cleared without status read");
  AST_OVR_FULL: assert property ($rose(o_rx_overrun_flag) |-> o_rx_full_flag)
    else $error("overrun without full holding");
  AST_RX_HOLD: assert property (o_rx_full_flag && $past(o_rx_full_flag) |-> $stable(o_rx_data))
    else $error("held receive word overwritten");
endmodule // spics_checker

// >>> testbench/spics_peer.sv
`timescale 1ns/1ps
// Serial peripheral on select line zero, clock mode 0, most significant bit first
module spics_peer #(
  parameter [7:0] REPLY = 8'h3c
) (
  input wire i_cs_n,
  input wire i_sclk,
  input wire i_mosi,
  output reg o_miso,
  output reg [7:0] o_got
);
  reg [7:0] sh; // Outgoing reply bits
  initial begin
    o_miso = 1'b0;
    o_got = 8'h00;
    sh = REPLY;
  end
  // Selection loads the reply and presents its top bit at once
  always @(negedge i_cs_n) begin
    sh = REPLY;
    o_miso = sh[7];
  end
  // Leading edge samples the master data
  always @(posedge i_sclk) begin
    if (!i_cs_n) o_got = {o_got[6:0], i_mosi};
  end
  // Trailing edge moves the next reply bit out
  always @(negedge i_sclk) begin
    if (!i_cs_n) begin
      sh = {sh[6:0], 1'b0};
      o_miso = sh[7];
    end
  end
  // Released line shows the inverse, so stale data never passes for a reply
  always @(posedge i_cs_n) o_miso = ~o_miso;
endmodule // spics_peer

// >>> testbench/testbench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module testbench;
  reg i_clk = 1'b0, i_rst = 1'b1, i_master = 1'b1, i_select_mode_bit = 1'b0;
  reg i_select_decode_bit = 1'b0, i_slow_clock_select = 1'b0, i_conflict_detect_off = 1'b0;
  reg [3:0] i_peripheral_select_field = 4'h6, i_clock_polarity_bit = 4'h0;
  reg [3:0] i_clock_phase_bit = 4'hf, i_hold_select_after_transfer = 4'h0;
  reg [7:0] i_cs_gap_delay = 8'h00;
  reg [31:0] i_clock_lead_delay = 32'h0808_0808, i_transfer_gap_delay = 32'h0101_0101;
  reg [31:0] i_baud_div = 32'h0404_0404, i_tx_word = 32'h0000_0000;
  reg [15:0] i_bits_len = 16'h0080;
  reg i_unit_enable_cmd = 1'b0, i_unit_disable_cmd = 1'b0, i_tx_write = 1'b0;
  reg i_status_read = 1'b0, i_rx_read = 1'b0, i_slave_select_in = 1'b1;
  reg i_serial_clock_pin = 1'b0, i_mosi = 1'b0;
  wire i_miso, o_serial_clock_out, o_serial_clock_oe, o_mosi, o_mosi_oe, o_miso, o_miso_oe;
  wire o_rx_full_flag, o_rx_overrun_flag, o_tx_empty_flag, o_master_conflict_flag;
  wire o_unit_enabled;
  wire [3:0] o_chip_select_lines, o_chip_select_oe, o_rx_pcs;
  wire [15:0] o_rx_data;
  wire [7:0] got; // Word seen by the peripheral
  int n_fail = 0;
  int check_count = 0;
  reg [3:0] s;
  reg [15:0] d;
  reg [7:0] g;
  spics_top #(.SLOW_DIV(4)) spics_top_inst (.i_clk, .i_rst, .i_master, .i_select_mode_bit,
    .i_select_decode_bit, .i_slow_clock_select, .i_conflict_detect_off,
    .i_peripheral_select_field, .i_cs_gap_delay, .i_clock_lead_delay, .i_transfer_gap_delay,
    .i_baud_div, .i_bits_len, .i_clock_polarity_bit, .i_clock_phase_bit,
    .i_hold_select_after_transfer, .i_unit_enable_cmd, .i_unit_disable_cmd, .i_tx_write,
    .i_tx_word, .i_status_read, .i_rx_read, .i_slave_select_in, .i_serial_clock_pin, .i_mosi,
    .i_miso, .o_chip_select_lines, .o_chip_select_oe, .o_serial_clock_out,
    .o_serial_clock_oe, .o_mosi, .o_mosi_oe, .o_miso, .o_miso_oe, .o_rx_data,
    .o_rx_pcs, .o_rx_full_flag, .o_rx_overrun_flag, .o_tx_empty_flag,
    .o_master_conflict_flag, .o_unit_enabled);
  spics_peer spics_peer_inst (.i_cs_n(o_chip_select_lines[0]), .i_sclk(o_serial_clock_out),
    .i_mosi(o_mosi), .o_miso(i_miso), .o_got(got));
  // 50 MHz system clock
  always #10 i_clk = ~i_clk;
  task cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task send(input [31:0] w);
    i_tx_word <= w;
    i_tx_write <= 1'b1;
    cyc(1);
    i_tx_write <= 1'b0;
    cyc(1);
  endtask
  task enable;
    i_unit_enable_cmd <= 1'b1;
    cyc(1);
    i_unit_enable_cmd <= 1'b0;
    cyc(2);
  endtask
  // Wait for a received word, keep it, then free the holding register
  task wait_full(output [15:0] dv);
    for (int k = 0; k < 3000 && o_rx_full_flag !== 1'b1; k++) cyc(1);
    `CHK(o_rx_full_flag, 1'b1)
    dv = o_rx_data;
    i_rx_read <= 1'b1;
    cyc(1);
    i_rx_read <= 1'b0;
    cyc(1);
  endtask
  // One master word; reports the first new select code seen
  task xfer(input [31:0] w, output [3:0] sv, output [15:0] dv);
    reg [3:0] c0;
    c0 = o_chip_select_lines;
    send(w);
    for (int k = 0; k < 400 && (o_chip_select_lines === 4'hf || o_chip_select_lines === c0);
         k++) cyc(1);
    sv = o_chip_select_lines;
    wait_full(dv);
  endtask
  // A word with no valid target must never lower a line
  task t_refuse;
    reg bad;
    bad = 1'b0;
    send(32'h000f_0011);
    for (int k = 0; k < 60; k++) begin
      cyc(1);
      if (o_chip_select_lines !== 4'hf) bad = 1'b1;
    end
    `CHK(bad, 1'b0)
    `CHK(o_tx_empty_flag, 1'b1)
  endtask
  task t_select;
    xfer(32'h000f_00a5, s, d);
    `CHK(s, 4'he)
    `CHK(d, 16'h003c)
    `CHK(got, 8'ha5)
    `CHK(o_rx_pcs, 4'he)
    cyc(20);
    `CHK(o_chip_select_lines, 4'hf)
    i_peripheral_select_field <= 4'hf;
    t_refuse();
    i_select_mode_bit <= 1'b1;
    i_peripheral_select_field <= 4'h0;
    xfer(32'h000d_0011, s, d);
    `CHK(s, 4'hd)
    `CHK(d, 16'hffff)
    xfer(32'h000a_0011, s, d);
    `CHK(s, 4'he)
    i_select_mode_bit <= 1'b0;
    i_select_decode_bit <= 1'b1;
    i_peripheral_select_field <= 4'h5;
    xfer(32'h0000_0011, s, d);
    `CHK(s, 4'h5)
    `CHK(d, 16'hffff)
    i_peripheral_select_field <= 4'hf;
    t_refuse();
    i_select_decode_bit <= 1'b0;
    cyc(2);
  endtask
  task t_hold;
    i_select_mode_bit <= 1'b1;
    i_hold_select_after_transfer <= 4'hf;
    xfer(32'h000e_00a5, s, d);
    cyc(30);
    `CHK(o_chip_select_lines, 4'he)
    xfer(32'h010d_0011, s, d);
    `CHK(s, 4'hd)
    cyc(30);
    `CHK(o_chip_select_lines, 4'hf)
    i_select_mode_bit <= 1'b0;
    i_hold_select_after_transfer <= 4'h0;
    cyc(2);
  endtask
  task t_fault;
    i_slave_select_in <= 1'b0;
    cyc(10);
    `CHK(o_master_conflict_flag, 1'b1)
    `CHK(o_unit_enabled, 1'b0)
    i_slave_select_in <= 1'b1;
    cyc(5);
    i_status_read <= 1'b1;
    cyc(1);
    i_status_read <= 1'b0;
    cyc(2);
    `CHK(o_master_conflict_flag, 1'b0)
    enable();
    `CHK(o_unit_enabled, 1'b1)
    i_conflict_detect_off <= 1'b1;
    cyc(2);
    i_slave_select_in <= 1'b0;
    cyc(10);
    `CHK(o_master_conflict_flag, 1'b0)
    i_slave_select_in <= 1'b1;
    cyc(5);
    i_conflict_detect_off <= 1'b0;
  endtask
  // Frame from the outside master: 160 ns clock, still between frames
  task frame(input [7:0] dout, output [7:0] gm);
    i_slave_select_in <= 1'b0;
    cyc(8);
    for (int i = 7; i >= 0; i--) begin
      i_mosi <= dout[i];
      cyc(4);
      i_serial_clock_pin <= 1'b1;
      gm[i] = o_miso;
      cyc(4);
      i_serial_clock_pin <= 1'b0;
    end
    `CHK({o_miso_oe, o_chip_select_oe}, 5'h10)
    cyc(8);
    i_slave_select_in <= 1'b1;
    i_mosi <= ~dout[0];
    cyc(10);
  endtask
  task t_slave;
    i_unit_disable_cmd <= 1'b1;
    cyc(1);
    i_unit_disable_cmd <= 1'b0;
    i_master <= 1'b0;
    cyc(2);
    enable();
    send(32'h0000_0096);
    cyc(3);
    `CHK(o_tx_empty_flag, 1'b1)
    frame(8'h5a, g);
    `CHK(g, 8'h96)
    `CHK(o_rx_full_flag, 1'b1)
    `CHK(o_rx_data, 16'h005a)
    frame(8'hc3, g);
    `CHK(g, 8'h5a)
    `CHK(o_rx_overrun_flag, 1'b1)
    `CHK(o_rx_data, 16'h005a)
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    cyc(12);
    i_rst <= 1'b0;
    cyc(1);
    `CHK(o_chip_select_lines, 4'hf)
    `CHK(o_tx_empty_flag, 1'b1)
    enable();
    `CHK({o_chip_select_oe, o_serial_clock_oe, o_mosi_oe, o_miso_oe}, 7'h7e)
    t_select();
    t_hold();
    t_fault();
    t_slave();
    final_report();
  end
  // Watchdog cuts a hang short well above the expected run time
  initial begin
    #1500000;
    n_fail++;
    final_report();
  end
endmodule // testbench
bind spics_top spics_checker #(.SLOW_DIV(SLOW_DIV)) spics_checker_inst (.i_clk, .i_rst,
  .i_select_mode_bit, .i_select_decode_bit, .i_conflict_detect_off,
  .i_peripheral_select_field, .i_clock_lead_delay, .i_status_read, .o_chip_select_lines,
  .o_serial_clock_out, .o_rx_data, .o_rx_full_flag, .o_rx_overrun_flag,
  .o_master_conflict_flag, .o_unit_enabled);
